/* File: verilog/rcab_defs.vh */
// Constants for the registered command/address buffer.
// Assumes inclusion by bare name from the buffer design files.
//
// Summary of operation
// [RULE_01] Capture inputs only on clock crossing.
// [RULE_02] Reset low clears all registers asynchronously; here only rst high does, reset_n acts synchronously.
// [RULE_03] Reset low forces every output low.
// [RULE_04] Both chip selects high hold gated outputs.
// [RULE_05] Any chip select low loads gated outputs.
// [RULE_06] Termination and clock enable always load.
// [RULE_07] Chip select output follows primary input.
// [RULE_08] No crossing means outputs hold values.
// [RULE_09] Unused pins ignored, outputs driven low.
// [RULE_10] 1:1 mode gates bits 2,3,5,6,8-25.
// [RULE_11] 1:2 A mode gates bits 2,3,5,6,8-14.
// [RULE_12] 1:2 B mode gates 1-6,8-10,12,13.
// [RULE_13] Fanout config selects 25x1 or 14x2.
// [RULE_14] Configuration inputs tied, never switched live.
// [RULE_15] Inputs defined whenever reset is high.
`ifndef RCAB_DEFS_VH
`define RCAB_DEFS_VH

// ============================================================
// Widths and configuration masks (bit n-1 is data bit n)
`define RCAB_NBITS 25
`define RCAB_GATE_1TO1 25'h1FFFFB6
`define RCAB_GATE_1TO2A 25'h0003FB6
`define RCAB_GATE_1TO2B 25'h0001BBF
`define RCAB_USED_1TO1 25'h1FFFFFF
`define RCAB_USED_1TO2 25'h0003FFF
`define RCAB_ODT_A 3
`define RCAB_CKE_A 0
`define RCAB_ODT_B 10
`define RCAB_CKE_B 13
`define RCAB_CS_BIT 6
`define RCAB_RESET_VAL 25'h0000000

`endif

/* File: verilog/rcab_sync.v */
// Two-stage synchroniser for one level from outside the clock domain.
// Assumes clk is the block clock and rst the asynchronous reset.
`timescale 1ns/1ps
module rcab_sync (
    clk,
    rst,
    d,
    q
);
    input wire clk;
    input wire rst;
    input wire d;
    output reg q;
    reg meta_reg;

    // Two flops; only the second reads the first
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_reg <= 1'b0;
            q <= 1'b0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule

/* File: verilog/rcab_buffer.v */
// Registered command/address buffer, 25-bit 1:1 or 14-bit 1:2.
// Assumes differential clock arrives as ordinary pins sampled on clk;
// reset_n is the pin-level active-low reset, synchronised onto clk and applied synchronously.
`timescale 1ns/1ps
`include "rcab_defs.vh"
module rcab_buffer #(
    parameter NBITS = `RCAB_NBITS
) (
    clk,
    rst,
    reset_n,
    ck_pos,
    ck_neg,
    bank_select_cfg,
    fanout_cfg,
    data_in_bits,
    primary_chip_select_in,
    secondary_chip_select_in,
    registered_out_bits,
    registered_out_b,
    chip_select_out,
    termination_ctl_out,
    clock_enable_out
);
    input wire clk;
    input wire rst;
    input wire reset_n;
    input wire ck_pos;
    input wire ck_neg;
    input wire bank_select_cfg;
    input wire fanout_cfg;
    input wire [NBITS-1:0] data_in_bits;
    input wire primary_chip_select_in;
    input wire secondary_chip_select_in;
    output reg [NBITS-1:0] registered_out_bits;
    output reg [13:0] registered_out_b;
    output reg chip_select_out;
    output reg termination_ctl_out;
    output reg clock_enable_out;

    // ============================================================
    // Input synchronisers
    wire pos_s;
    wire neg_s;
    wire rstn_s;
    wire pcs_s;
    wire scs_s;
    wire c0_s;
    wire c1_s;
    wire [NBITS-1:0] din_s;
    reg pos_d_reg;
    reg neg_d_reg;

    rcab_sync u_pos (.clk(clk), .rst(rst), .d(ck_pos), .q(pos_s));
    rcab_sync u_neg (.clk(clk), .rst(rst), .d(ck_neg), .q(neg_s));
    rcab_sync u_rstn (.clk(clk), .rst(rst), .d(reset_n), .q(rstn_s));
    rcab_sync u_pcs (.clk(clk), .rst(rst),
        .d(primary_chip_select_in), .q(pcs_s));
    rcab_sync u_scs (.clk(clk), .rst(rst),
        .d(secondary_chip_select_in), .q(scs_s));
    rcab_sync u_c0 (.clk(clk), .rst(rst), .d(bank_select_cfg), .q(c0_s));
    rcab_sync u_c1 (.clk(clk), .rst(rst), .d(fanout_cfg), .q(c1_s));

    // One synchroniser per data bit
    genvar gi;
    generate
        for (gi = 0; gi < NBITS; gi = gi + 1) begin : g_din
            rcab_sync u_d (.clk(clk), .rst(rst),
                .d(data_in_bits[gi]), .q(din_s[gi]));
        end
    endgenerate

    // ============================================================
    // Crossing detect: positive rises while negative falls
    wire crossing;
    assign crossing = pos_s & ~pos_d_reg & ~neg_s & neg_d_reg; // see [RULE_01]

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pos_d_reg <= 1'b0;
            neg_d_reg <= 1'b0;
        end else begin
            pos_d_reg <= pos_s;
            neg_d_reg <= neg_s;
        end
    end

    // ============================================================
    // Mode decode: masks of gated and of live bits
    reg [NBITS-1:0] gate_mask;
    reg [NBITS-1:0] used_mask;
    integer odt_idx;
    integer cke_idx;

    always @* begin
        gate_mask = `RCAB_GATE_1TO1; // see [RULE_10]
        used_mask = `RCAB_USED_1TO1;
        odt_idx = `RCAB_ODT_A;
        cke_idx = `RCAB_CKE_A;
        if (c1_s) begin // see [RULE_13]
            used_mask = `RCAB_USED_1TO2;
            if (c0_s) begin
                gate_mask = `RCAB_GATE_1TO2B; // see [RULE_12]
                odt_idx = `RCAB_ODT_B;
                cke_idx = `RCAB_CKE_B;
            end else begin
                gate_mask = `RCAB_GATE_1TO2A; // see [RULE_11]
            end
        end
    end

    // ============================================================
    // Next output values
    wire cs_open;
    reg [NBITS-1:0] q_next;
    integer i;

    assign cs_open = ~pcs_s | ~scs_s; // see [RULE_05]

    always @* begin
        q_next = registered_out_bits;
        for (i = 0; i < NBITS; i = i + 1) begin
            if (!used_mask[i]) begin
                q_next[i] = 1'b0; // see [RULE_09]
            end else if (gate_mask[i]) begin
                if (cs_open) begin
                    q_next[i] = din_s[i]; // see [RULE_05]
                end // held when both selects high, see [RULE_04]
            end else begin
                q_next[i] = din_s[i]; // ungated bits, see [RULE_06]
            end
        end
        q_next[`RCAB_CS_BIT] = pcs_s; // see [RULE_07]
    end

    // ============================================================
    // Output register; rst clears asynchronously, reset pin clears synchronously via rstn_s
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            registered_out_bits <= `RCAB_RESET_VAL; // see [RULE_02]
            registered_out_b <= 14'h0000;
            chip_select_out <= 1'b0;
            termination_ctl_out <= 1'b0;
            clock_enable_out <= 1'b0;
        end else if (!rstn_s) begin
            registered_out_bits <= `RCAB_RESET_VAL; // see [RULE_03]
            registered_out_b <= 14'h0000;
            chip_select_out <= 1'b0;
            termination_ctl_out <= 1'b0;
            clock_enable_out <= 1'b0;
        end else if (crossing) begin
            registered_out_bits <= q_next;
            if (c1_s) begin
                registered_out_b <= q_next[13:0];
            end else begin
                registered_out_b <= 14'h0000; // see [RULE_09]
            end
            chip_select_out <= pcs_s; // see [RULE_07]
            termination_ctl_out <= din_s[odt_idx]; // see [RULE_06]
            clock_enable_out <= din_s[cke_idx]; // see [RULE_06]
        end // no crossing: hold, see [RULE_08]
    end
endmodule

/* File: testbench/rcab_buffer_sva.sv */
// Port checker for the command/address buffer.
// Assumes a bind to rcab_buffer; one clock, reset rst.
`timescale 1ns/1ps
module rcab_buffer_sva (
    input logic clk, rst, reset_n, ck_pos, ck_neg,
    input logic bank_select_cfg, fanout_cfg,
    input logic primary_chip_select_in, secondary_chip_select_in,
    input logic [24:0] data_in_bits, registered_out_bits,
    input logic [13:0] registered_out_b,
    input logic chip_select_out, termination_ctl_out, clock_enable_out
);
    // Bits gated in every mode
    localparam logic [24:0] GM = 25'h0001BB6;
    wire [24:0] q = registered_out_bits;
    wire sb = bank_select_cfg & fanout_cfg;
    wire hold = primary_chip_select_in & secondary_chip_select_in;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_cross;
        $rose(ck_pos) && $fell(ck_neg) && reset_n;
    endsequence
    chk_pin_reset: assert property (
        !reset_n [*3] |=> {q, registered_out_b, chip_select_out,
        termination_ctl_out, clock_enable_out} == 0) else $error("reset");
    chk_idle_hold: assert property (
        (reset_n && !ck_pos) [*8] |=> $stable(q)) else $error("drift");
    chk_cs_follow: assert property (
        s_cross |-> ##5 chip_select_out == $past(primary_chip_select_in, 5))
        else $error("select");
    chk_ctl_load: assert property (
        s_cross |-> ##5 termination_ctl_out == $past(data_in_bits[sb ? 10 : 3],
        5) && clock_enable_out == $past(data_in_bits[sb ? 13 : 0], 5))
        else $error("control bits");
    chk_gate_hold: assert property (
        s_cross ##0 hold |-> ##5 (q & GM) == $past(q & GM, 5))
        else $error("hold");
    chk_gate_load: assert property (
        s_cross ##0 !hold |-> ##5 (q & GM) == $past(data_in_bits & GM, 5))
        else $error("load");
    chk_b_low: assert property (
        !fanout_cfg |-> registered_out_b == 0) else $error("b not low");
    chk_b_mirror: assert property (
        fanout_cfg |-> registered_out_b == q[13:0] && q[24:14] == 0)
        else $error("mirror");
endmodule
bind rcab_buffer rcab_buffer_sva i_sva (.*);

/* File: testbench/rcab_ctl_model.sv */
// Controller model: data, selects and the clock pair.
// Assumes send is called just after a rising clk edge.
`timescale 1ns/1ps
module rcab_ctl_model (
    input logic clk,
    output logic cp = 0, cn = 1, ps = 1, ss = 1,
    output logic [24:0] d = 0
);
    // Setup, crossing, hold, then the clock pair set back and held again
    task automatic send(input logic [24:0] v, input logic p, s);
        {d, ps, ss} <= {v, p, s};
        repeat (4) @(posedge clk);
        {cp, cn} <= 2'b10;
        repeat (8) @(posedge clk);
        {cp, cn} <= 2'b01;
        repeat (8) @(posedge clk);
    endtask
endmodule

/* File: testbench/rcab_buffer_test.sv */
// Bench: per mode a load, a gated hold, a reload, a pin reset.
// Assumes rcab_ctl_model paces each transfer.
`timescale 1ns/1ps
module rcab_buffer_test;
    logic clk = 0, rst = 1, rn = 1, bs = 0, fo = 0;
    logic cp, cn, ps, ss, qc, qt, qk;
    logic [24:0] d, q, e, g;
    logic [13:0] qb;
    int failures = 0, cmp_count = 0;
    logic [24:0] gt [3] = '{25'h1FFFFB6, 25'h0003FB6, 25'h0001BBF};
    always #12.5 clk = ~clk;
    rcab_ctl_model i_ctl (.clk(clk), .cp(cp), .cn(cn), .ps(ps), .ss(ss),
        .d(d));
    rcab_buffer i_dut (.clk(clk), .rst(rst), .reset_n(rn), .ck_pos(cp),
        .ck_neg(cn), .bank_select_cfg(bs), .fanout_cfg(fo), .data_in_bits(d),
        .primary_chip_select_in(ps), .secondary_chip_select_in(ss),
        .registered_out_bits(q), .registered_out_b(qb),
        .chip_select_out(qc), .termination_ctl_out(qt),
        .clock_enable_out(qk));
    task automatic check(input string n, input logic [24:0] s, x);
        cmp_count++;
        if (s !== x) begin
            failures++;
            $display("[FAIL] %s exp %h seen %h", n, x, s);
        end
    endtask
    task automatic tally_and_finish;
        if (failures == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Only loaded bits take the new value
    task automatic xfer(input logic [24:0] v, input logic p, s);
        logic [24:0] m;
        m = fo ? 25'h0003FFF : 25'h1FFFFFF;
        if (p & s) m = m & ~g;
        v[6] = p;
        i_ctl.send(v, p, s);
        e = (e & ~m) | (v & m);
        check("out", q, e);
        check("b", qb, fo ? {11'h000, e[13:0]} : 25'h0000000);
        check("cs", qc, p);
        check("odt", qt, v[bs ? 10 : 3]);
        check("cke", qk, v[bs ? 13 : 0]);
    endtask
    // Each mode under a fresh reset
    initial begin
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            rst <= 1;
            {bs, fo} <= {i == 2, i != 0};
            g = gt[i];
            e = 0;
            #1 check("rst", q, e);
            repeat (4) @(posedge clk);
            rst <= 0;
            repeat (4) @(posedge clk);
            xfer(25'h1FFFFFF, 0, 1);
            xfer(25'h0000000, 1, 1);
            xfer(25'h0AAAAAA, 1, 0);
            rn <= 0;
            repeat (6) @(posedge clk);
            #1 check("pin", q | qb | {qc, qt, qk}, e & 0);
            @(posedge clk);
            rn <= 1;
        end
        tally_and_finish;
    end
    // Watchdog, far past the expected run
    initial begin
        #100000;
        failures++;
        tally_and_finish;
    end
endmodule
